// File: inc/atd_pkg.sv
// Package for the adaptive threshold detector: register map and constants
package atd_pkg;
   // ************************************************************
   // Register byte offsets (APB, one word each)
   // ************************************************************
   localparam logic [7:0] ATD_OFS_STATUS   = 8'h00;
   localparam logic [7:0] ATD_OFS_DATA1    = 8'h04;
   localparam logic [7:0] ATD_OFS_DATA2    = 8'h08;
   localparam logic [7:0] ATD_OFS_AVG1     = 8'h0C;
   localparam logic [7:0] ATD_OFS_AVG2     = 8'h10;
   localparam logic [7:0] ATD_OFS_SENS1    = 8'h14;
   localparam logic [7:0] ATD_OFS_TMO1     = 8'h18;
   localparam logic [7:0] ATD_OFS_SETUP1   = 8'h1C;
   localparam logic [7:0] ATD_OFS_SENS2    = 8'h20;
   localparam logic [7:0] ATD_OFS_TMO2     = 8'h24;
   localparam logic [7:0] ATD_OFS_SETUP2   = 8'h28;
   localparam logic [7:0] ATD_OFS_CONFIG   = 8'h2C;
   localparam logic [7:0] ATD_OFS_PDTIMER  = 8'h30;
   localparam logic [7:0] ATD_OFS_DAC1     = 8'h34;
   localparam logic [7:0] ATD_OFS_DAC2     = 8'h38;
   localparam logic [7:0] ATD_OFS_WAKE     = 8'h3C;
   localparam logic [7:0] ATD_OFS_CHIPID   = 8'h40;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] ATD_RST_SENS     = 8'h08;
   localparam logic [7:0] ATD_RST_TMO      = 8'h86;
   localparam logic [7:0] ATD_RST_SETUP    = 8'h00;
   localparam logic [7:0] ATD_RST_CONFIG   = 8'h19;
   localparam logic [7:0] ATD_RST_PDTIMER  = 8'h40;
   localparam logic [7:0] ATD_RST_DAC      = 8'hC0;
   // Arbitrary neutral identity value
   localparam logic [7:0] ATD_CHIP_ID      = 8'h5A;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ATD_SETUP_HYST  = 4;
   localparam int ATD_SETUP_RNGL  = 6;
   localparam int ATD_CFG_FIXED   = 7;
   localparam int ATD_CFG_MD1     = 6;
   localparam int ATD_CFG_MD0     = 5;
   localparam int ATD_DAC_EN      = 7;
   localparam int ATD_DAC_AUTO    = 6;
   localparam int ATD_PD_EN       = 6;
   // ************************************************************
   // Algorithm constants
   // ************************************************************
   localparam logic [15:0] ATD_AVG_HIGH   = 16'hA800;
   localparam logic [15:0] ATD_AVG_LOW    = 16'h5800;
   localparam logic [5:0]  ATD_DAC_FULL   = 6'h3F;
   // Result LSB of the 12-bit converter within 16-bit data
   localparam int          ATD_LSB_SHIFT  = 4;
   // Conversions per power-down timer tick
   localparam int          ATD_PD_TICK    = 16;
   typedef enum logic [1:0] {
      ATD_THR_NEG,
      ATD_THR_POS,
      ATD_THR_INWIN,
      ATD_THR_OUTWIN
   } atd_thr_mode_type;
endpackage

// File: hdl/atd_detector.sv
// Two-channel threshold detector with APB register access
`timescale 1ns/1ns
// How it works
// - Compare each result with fixed or adaptive threshold
// - Active-high output, positive or negative change
// - Adaptive window mode, inside or outside band
// - Fixed mode: output tracks threshold crossing
// - Threshold is average plus/minus sensitivity
// - Average moves by difference over 2^(s+1)
// - Adaptive hysteresis quarter sensitivity, switchable
// - No hysteresis in fixed mode
// - Timeout counts only outside average band
// - Expired timeout loads average with result
// - Separate approach and recede timeout lengths
// - Auto DAC increments above high limit
// - Auto DAC decrements below low limit
// - DAC step depends on input range
// - DAC clamps at zero and full scale
// - DAC setting is six bits, monotonic
// - Power-down after idle period without detection
// - Host command or reset leaves power-down
// - Results readable by host and used
// - Output pins high on channel detection
module atd_detector
   import atd_pkg::*;
#(
   parameter int CH_COUNT = 2
) (
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   input  wire logic        clk_en_in,
   input  wire logic [1:0]  conv_valid_in,
   input  wire logic [15:0] conv_data_first_in,
   input  wire logic [15:0] conv_data_second_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             detect_out_first_out,
   output logic             detect_out_second_out,
   output logic [5:0]       offset_cap_dac_first_out,
   output logic [5:0]       offset_cap_dac_second_out,
   output logic             power_down_out
);
   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]  sens_q   [CH_COUNT];
   logic [7:0]  tmo_q    [CH_COUNT];
   logic [7:0]  setup_q  [CH_COUNT];
   logic [7:0]  dacreg_q [CH_COUNT];
   logic [15:0] data_q   [CH_COUNT];
   logic [15:0] avg_q    [CH_COUNT];
   logic [3:0]  tcnt_q   [CH_COUNT];
   logic [CH_COUNT-1:0] det_q;
   logic [CH_COUNT-1:0] rdy_q;
   logic [7:0]  config_q;
   logic [7:0]  pdtimer_q;
   logic [9:0]  pdcnt_q;
   logic        pd_q;
   logic [15:0] conv_data [CH_COUNT];
   logic        wr_en;
   logic        rd_en;
   logic        wake_cmd;
   logic [CH_COUNT-1:0] wr_sens;
   logic [CH_COUNT-1:0] wr_tmo;
   logic [CH_COUNT-1:0] wr_setup;
   logic [CH_COUNT-1:0] wr_dac;
   logic [CH_COUNT-1:0] conv_ok;
   atd_thr_mode_type    thr_mode;
   logic                fixed_mode;

   assign conv_data[0] = conv_data_first_in;
   assign conv_data[1] = conv_data_second_in;
   assign fixed_mode   = config_q[ATD_CFG_FIXED];
   assign thr_mode     = atd_thr_mode_type'({config_q[ATD_CFG_MD1],
                                             config_q[ATD_CFG_MD0]});
   // Access phase completes in one cycle; pready always high
   assign wr_en    = psel_in & penable_in & pwrite_in & clk_en_in;
   assign rd_en    = psel_in & ~penable_in & ~pwrite_in & clk_en_in;
   assign wake_cmd = wr_en && paddr_in == ATD_OFS_WAKE;

   // ************************************************************
   // Per-channel engine
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < CH_COUNT; gi++) begin : g_ch
         localparam logic [7:0] OFS_SENS  = gi ? ATD_OFS_SENS2
                                               : ATD_OFS_SENS1;
         localparam logic [7:0] OFS_TMO   = gi ? ATD_OFS_TMO2
                                               : ATD_OFS_TMO1;
         localparam logic [7:0] OFS_SETUP = gi ? ATD_OFS_SETUP2
                                               : ATD_OFS_SETUP1;
         localparam logic [7:0] OFS_DAC   = gi ? ATD_OFS_DAC2
                                               : ATD_OFS_DAC1;
         logic signed [17:0] diff;
         logic signed [17:0] step;
         logic [17:0] sens_w;
         logic [17:0] hyst_w;
         logic [17:0] up_thr;
         logic [17:0] dn_thr;
         logic [15:0] fix_thr;
         logic        above;
         logic        below;
         logic        hyst_on;
         logic        det_d;
         logic        outside;
         logic        approach;
         logic [3:0]  tlimit;
         logic [15:0] avg_d;
         logic [5:0]  dstep;
         logic [5:0]  dval;
         logic        dauto;

         assign wr_sens[gi]  = wr_en && paddr_in == OFS_SENS;
         assign wr_tmo[gi]   = wr_en && paddr_in == OFS_TMO;
         assign wr_setup[gi] = wr_en && paddr_in == OFS_SETUP;
         assign wr_dac[gi]   = wr_en && paddr_in == OFS_DAC;
         // Channel idles while powered down or disabled
         assign conv_ok[gi]  = conv_valid_in[gi] & ~pd_q
                               & config_q[4 - gi];

         // Sensitivity is in 12-bit LSBs; data is 16-bit
         assign sens_w  = 18'(sens_q[gi]) << ATD_LSB_SHIFT;
         assign hyst_w  = sens_w >> 2;
         assign hyst_on = setup_q[gi][ATD_SETUP_HYST]
                          & ~fixed_mode;
         assign fix_thr = {sens_q[gi], tmo_q[gi]};
         assign up_thr  = 18'(avg_q[gi]) + sens_w;
         assign dn_thr  = 18'(avg_q[gi]) - sens_w;
         assign diff    = 18'(conv_data[gi]) - 18'(avg_q[gi]);
         assign step    = diff >>> (5'(setup_q[gi][3:0]) + 5'h01);

         always_comb begin
            above = 1'b0;
            below = 1'b0;
            if (fixed_mode) begin
               above = conv_data[gi] > fix_thr;
               below = conv_data[gi] < fix_thr;
            end else begin
               // Hysteresis moves the release point inward
               above = det_q[gi] && hyst_on
                       ? 18'(conv_data[gi]) + hyst_w > up_thr
                       : 18'(conv_data[gi]) > up_thr;
               // Signed: a low average pushes dn_thr below zero
               below = $signed(18'(conv_data[gi]))
                       < $signed(det_q[gi] && hyst_on
                                 ? dn_thr + hyst_w : dn_thr);
            end
            unique case (thr_mode)
               ATD_THR_NEG:    det_d = below;
               ATD_THR_POS:    det_d = above;
               ATD_THR_INWIN:  det_d = fixed_mode ? above
                                       : ~(above | below);
               ATD_THR_OUTWIN: det_d = fixed_mode ? above
                                       : (above | below);
            endcase
         end

         assign outside  = 18'(conv_data[gi]) > up_thr
                           || (!dn_thr[17]
                               && 18'(conv_data[gi]) < dn_thr);
         // Toward the threshold: up in positive, down otherwise
         assign approach = (thr_mode == ATD_THR_POS)
                           ? conv_data[gi] > avg_q[gi]
                           : conv_data[gi] < avg_q[gi];
         assign tlimit   = approach ? tmo_q[gi][7:4]
                                    : tmo_q[gi][3:0];
         assign avg_d    = 16'(18'(avg_q[gi]) + step);
         // Wider input range takes a larger DAC step
         assign dstep    = setup_q[gi][7] ? 6'h04
                         : setup_q[gi][ATD_SETUP_RNGL] ? 6'h02
                         : 6'h01;
         assign dval     = dacreg_q[gi][5:0];
         assign dauto    = dacreg_q[gi][ATD_DAC_AUTO] & ~fixed_mode;

         always_ff @(posedge mclk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               data_q[gi] <= 16'h0000;
               avg_q[gi]  <= 16'h0000;
               tcnt_q[gi] <= 4'h0;
               det_q[gi]  <= 1'b0;
               rdy_q[gi]  <= 1'b1;
            end else if (clk_en_in) begin
               if (conv_ok[gi]) begin
                  data_q[gi] <= conv_data[gi];
                  rdy_q[gi]  <= 1'b0;
                  det_q[gi]  <= det_d;
                  if (!fixed_mode && outside && tlimit != 4'h0) begin
                     if (tcnt_q[gi] + 4'h1 >= tlimit) begin
                        avg_q[gi]  <= conv_data[gi];
                        tcnt_q[gi] <= 4'h0;
                     end else begin
                        avg_q[gi]  <= avg_d;
                        tcnt_q[gi] <= tcnt_q[gi] + 4'h1;
                     end
                  end else begin
                     avg_q[gi]  <= avg_d;
                     tcnt_q[gi] <= 4'h0;
                  end
               end else if (rd_en
                            && paddr_in == (gi ? ATD_OFS_DATA2
                                               : ATD_OFS_DATA1)) begin
                  rdy_q[gi] <= 1'b1;
               end
            end
         end

         always_ff @(posedge mclk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               sens_q[gi]   <= ATD_RST_SENS;
               tmo_q[gi]    <= ATD_RST_TMO;
               setup_q[gi]  <= ATD_RST_SETUP;
               dacreg_q[gi] <= ATD_RST_DAC;
            end else if (clk_en_in) begin
               if (wr_sens[gi])
                  sens_q[gi] <= pwdata_in[7:0];
               if (wr_tmo[gi])
                  tmo_q[gi] <= pwdata_in[7:0];
               if (wr_setup[gi])
                  setup_q[gi] <= pwdata_in[7:0];
               if (wr_dac[gi]) begin
                  dacreg_q[gi] <= pwdata_in[7:0];
               end else if (conv_ok[gi] && dauto) begin
                  if (avg_q[gi] > ATD_AVG_HIGH) begin
                     dacreg_q[gi][5:0] <= (dval > ATD_DAC_FULL - dstep)
                                          ? ATD_DAC_FULL
                                          : dval + dstep;
                  end else if (avg_q[gi] < ATD_AVG_LOW) begin
                     dacreg_q[gi][5:0] <= (dval < dstep) ? 6'h00
                                          : dval - dstep;
                  end
               end
            end
         end
      end
   endgenerate

   // ************************************************************
   // Global configuration and power-down timer
   // ************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         config_q  <= ATD_RST_CONFIG;
         pdtimer_q <= ATD_RST_PDTIMER;
      end else if (clk_en_in) begin
         if (wr_en && paddr_in == ATD_OFS_CONFIG)
            config_q <= pwdata_in[7:0];
         if (wr_en && paddr_in == ATD_OFS_PDTIMER)
            pdtimer_q <= pwdata_in[7:0];
      end
   end

   // Timer counts conversions; a coarse tick keeps it small
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pdcnt_q <= 10'h000;
         pd_q    <= 1'b0;
      end else if (clk_en_in) begin
         if (wake_cmd) begin
            pd_q    <= 1'b0;
            pdcnt_q <= 10'h000;
         end else if (|det_q || !pdtimer_q[ATD_PD_EN]
                      || pdtimer_q[5:0] == 6'h00) begin
            pdcnt_q <= 10'h000;
         end else if (|conv_ok) begin
            if (pdcnt_q[9:4] >= pdtimer_q[5:0])
               pd_q <= 1'b1;
            else
               pdcnt_q <= pdcnt_q + 10'h001;
         end
      end
   end

   // ************************************************************
   // Outputs and read data
   // ************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         detect_out_first_out      <= 1'b0;
         detect_out_second_out     <= 1'b0;
         offset_cap_dac_first_out  <= 6'h00;
         offset_cap_dac_second_out <= 6'h00;
         power_down_out            <= 1'b0;
      end else if (clk_en_in) begin
         detect_out_first_out      <= det_q[0];
         detect_out_second_out     <= det_q[1];
         offset_cap_dac_first_out  <= dacreg_q[0][ATD_DAC_EN]
                                      ? dacreg_q[0][5:0] : 6'h00;
         offset_cap_dac_second_out <= dacreg_q[1][ATD_DAC_EN]
                                      ? dacreg_q[1][5:0] : 6'h00;
         power_down_out            <= pd_q;
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b1;
         pslverr_out <= 1'b0;
      end else if (clk_en_in) begin
         pready_out <= 1'b1;
         if (psel_in && !penable_in) begin
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            unique case (paddr_in)
               ATD_OFS_STATUS:  prdata_out[7:0] <= {pd_q,
                  dacreg_q[1][ATD_DAC_AUTO], det_q[1],
                  dacreg_q[0][ATD_DAC_AUTO], det_q[0], 1'b0,
                  rdy_q[1], rdy_q[0]};
               ATD_OFS_DATA1:   prdata_out[15:0] <= data_q[0];
               ATD_OFS_DATA2:   prdata_out[15:0] <= data_q[1];
               ATD_OFS_AVG1:    prdata_out[15:0] <= avg_q[0];
               ATD_OFS_AVG2:    prdata_out[15:0] <= avg_q[1];
               ATD_OFS_SENS1:   prdata_out[7:0]  <= sens_q[0];
               ATD_OFS_TMO1:    prdata_out[7:0]  <= tmo_q[0];
               ATD_OFS_SETUP1:  prdata_out[7:0]  <= setup_q[0];
               ATD_OFS_SENS2:   prdata_out[7:0]  <= sens_q[1];
               ATD_OFS_TMO2:    prdata_out[7:0]  <= tmo_q[1];
               ATD_OFS_SETUP2:  prdata_out[7:0]  <= setup_q[1];
               ATD_OFS_CONFIG:  prdata_out[7:0]  <= config_q;
               ATD_OFS_PDTIMER: prdata_out[7:0]  <= pdtimer_q;
               ATD_OFS_DAC1:    prdata_out[7:0]  <= dacreg_q[0];
               ATD_OFS_DAC2:    prdata_out[7:0]  <= dacreg_q[1];
               ATD_OFS_WAKE:    prdata_out[7:0]  <= 8'h00;
               ATD_OFS_CHIPID:  prdata_out[7:0]  <= ATD_CHIP_ID;
               default:         pslverr_out      <= 1'b1;
            endcase
         end
      end
   end
endmodule // atd_detector

// File: test/atd_detector_asserts.sv
// Checker: port-level properties of the threshold detector
`timescale 1ns/1ns
module atd_detector_asserts
   import atd_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   input  wire logic [1:0] conv_valid_in,
   input  wire logic       psel_in,
   input  wire logic       penable_in,
   input  wire logic       pwrite_in,
   input  wire logic [7:0] paddr_in,
   input  wire logic       pready_out,
   input  wire logic       pslverr_out,
   input  wire logic       detect_out_first_out,
   input  wire logic       detect_out_second_out,
   input  wire logic [5:0] offset_cap_dac_first_out,
   input  wire logic       power_down_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   chk_det_first_lat: assert property (
      $changed(detect_out_first_out) |-> $past(conv_valid_in[0], 2))
      else $error("First detect moved without its conversion");
   chk_det_second_lat: assert property (
      $changed(detect_out_second_out) |-> $past(conv_valid_in[1], 2))
      else $error("Second detect moved without its conversion");
   chk_pd_idle: assert property (
      $rose(power_down_out) |-> !detect_out_first_out
      && !detect_out_second_out) else $error("Power-down while detecting");
   chk_pd_frozen: assert property (
      $past(power_down_out, 2) |-> $stable(detect_out_first_out))
      else $error("Detect moved while powered down");
   chk_pd_wake: assert property (
      $fell(power_down_out) |-> $past(psel_in && penable_in && pwrite_in
      && paddr_in == ATD_OFS_WAKE, 2)) else $error("Wake without command");
   chk_dac_step: assert property (
      $changed(offset_cap_dac_first_out)
      && !$past(psel_in && penable_in && pwrite_in, 2)
      |-> ((offset_cap_dac_first_out > $past(offset_cap_dac_first_out))
      ? offset_cap_dac_first_out - $past(offset_cap_dac_first_out)
      : $past(offset_cap_dac_first_out) - offset_cap_dac_first_out)
      <= 6'h04) else $error("Auto offset step too large");
   chk_apb_ready: assert property (
      psel_in && penable_in |-> pready_out) else $error("No ready");
   chk_apb_unmapped: assert property (
      psel_in && penable_in && paddr_in > ATD_OFS_CHIPID |-> pslverr_out)
      else $error("Unmapped access not flagged");
endmodule // atd_detector_asserts
bind atd_detector atd_detector_asserts u_chk (.mclk_in(mclk_in),
   .arst_n_in(arst_n_in), .conv_valid_in(conv_valid_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .detect_out_first_out(detect_out_first_out),
   .detect_out_second_out(detect_out_second_out),
   .offset_cap_dac_first_out(offset_cap_dac_first_out),
   .power_down_out(power_down_out));

// File: test/atd_host_model.sv
// Host model: APB master for register reads and writes
`timescale 1ns/1ns
module atd_host_model (
   input  wire logic        clk_in,
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [7:0]       paddr_out,
   output logic [31:0]      pwdata_out,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pready_in,
   input  wire logic        pslverr_in
);
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0;
   end
   // Request held until ready is seen; no wait count assumed
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= wr;
      paddr_out <= a;
      pwdata_out <= wd;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do @(posedge clk_in); while (pready_in !== 1'b1);
      rd = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
   endtask
endmodule // atd_host_model

// File: test/atd_detector_tb.sv
// Testbench: self-checking bench for the threshold detector
`timescale 1ns/1ns
module atd_detector_tb;
   import atd_pkg::*;
   logic        mclk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        clk_en_in = 1'b1;
   logic [1:0]  conv_valid_in = 2'h0;
   logic [15:0] d1 = 16'h0000;
   logic [15:0] d2 = 16'h0000;
   logic        psel, penable, pwrite, pready, pslverr, err, det1, det2, pd;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [5:0]  dac1, dac2;
   logic [15:0] dv;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          avg, dac, st, s;
   localparam logic [7:0] RA [9] = '{ATD_OFS_SENS1, ATD_OFS_TMO1,
      ATD_OFS_SETUP1, ATD_OFS_CONFIG, ATD_OFS_PDTIMER, ATD_OFS_DAC1,
      ATD_OFS_DAC2, ATD_OFS_CHIPID, 8'h44};
   localparam logic [7:0] RV [9] = '{ATD_RST_SENS, ATD_RST_TMO,
      ATD_RST_SETUP, ATD_RST_CONFIG, ATD_RST_PDTIMER, ATD_RST_DAC,
      ATD_RST_DAC, ATD_CHIP_ID, 8'h00};
   localparam int DL [4] = '{1024, -1024, 256, -256};
   localparam logic [15:0] HY [5] = '{16'h8400, 16'h81C0, 16'h8100,
      16'h8400, 16'h81C0};
   localparam logic HX [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   always #10 mclk_in = ~mclk_in;
   atd_host_model u_host (.clk_in(mclk_in), .psel_out(psel),
      .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
      .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(pslverr));
   atd_detector u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in), .conv_valid_in(conv_valid_in),
      .conv_data_first_in(d1), .conv_data_second_in(d2), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .detect_out_first_out(det1),
      .detect_out_second_out(det2), .offset_cap_dac_first_out(dac1),
      .offset_cap_dac_second_out(dac2), .power_down_out(pd));
   // ***********************************************************
   // Helpers
   // ***********************************************************
   task automatic results;
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      u_host.xfer(1'b1, a, {24'h0, v}, rdv, err);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, rdv, err);
   endtask
   task automatic conv(input logic [15:0] a);
      @(posedge mclk_in);
      conv_valid_in <= 2'h3;
      d1 <= a;
      d2 <= a ^ 16'h0F00;
      @(posedge mclk_in);
      conv_valid_in <= 2'h0;
      repeat (3) @(posedge mclk_in);
   endtask
   // Timeouts of one conversion force the average onto 0x8000
   task automatic snap;
      wr(ATD_OFS_TMO1, 8'h11);
      repeat (4) conv(16'h0000);
      repeat (4) conv(16'h8000);
      wr(ATD_OFS_TMO1, 8'h00);
   endtask
   function automatic logic det_exp(input logic [1:0] m, input logic fx,
      input int av, input int sn, input int d);
      if (fx)
         return (m == ATD_THR_NEG) ? (d < av) : (d > av);
      case (m)
         ATD_THR_NEG: return d < av - sn;
         ATD_THR_POS: return d > av + sn;
         ATD_THR_INWIN: return d > av - sn && d < av + sn;
         default: return d < av - sn || d > av + sn;
      endcase
   endfunction
   // ***********************************************************
   // Sequence
   // ***********************************************************
   initial begin
      void'($urandom(32'hC86E));
      repeat (2) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(RA[i]);
         cmp_word(rdv, {24'h0, RV[i]});
         cmp_bit(err, i == 8);
      end
      cmp_word({26'h0, dac1}, 32'h0);
      cmp_word({26'h0, dac2}, 32'h0);
      // Clock enable low must freeze the conversion capture
      clk_en_in <= 1'b0;
      conv(16'h1234);
      clk_en_in <= 1'b1;
      rd(ATD_OFS_DATA1);
      cmp_word(rdv, 32'h0);
      wr(ATD_OFS_PDTIMER, 8'h00);
      wr(ATD_OFS_WAKE, 8'h01);
      wr(ATD_OFS_SENS1, 8'h80);
      wr(ATD_OFS_TMO1, 8'h00);
      wr(ATD_OFS_SENS2, 8'h80);
      wr(ATD_OFS_TMO2, 8'h00);
      wr(ATD_OFS_SETUP1, 8'h10);
      wr(ATD_OFS_SETUP2, 8'h10);
      for (int m = 0; m < 4; m++) begin
         wr(ATD_OFS_CONFIG, 8'(8'h98 | (m << 5)));
         for (int k = 0; k < 6; k++) begin
            dv = (k == 0) ? 16'h8011 : (k == 1) ? 16'h7FF1
               : 16'($urandom) | 16'h0001;
            conv(dv);
            cmp_bit(det1, det_exp(2'(m), 1'b1, 32'h8000, 0, dv));
            cmp_bit(det2, det_exp(2'(m), 1'b1, 32'h8000, 0, dv ^ 16'h0F00));
            rd(ATD_OFS_DATA1);
            cmp_word(rdv, {16'h0, dv});
         end
      end
      // Slowest settling moves the average at most one LSB per conversion while probing
      wr(ATD_OFS_SETUP1, 8'h0F);
      wr(ATD_OFS_SENS1, 8'h20);
      wr(ATD_OFS_CONFIG, 8'h38);
      snap();
      rd(ATD_OFS_AVG1);
      cmp_word(rdv, 32'h8000);
      for (int m = 0; m < 4; m++) begin
         wr(ATD_OFS_CONFIG, 8'(8'h18 | (m << 5)));
         foreach (DL[j]) begin
            conv(16'(32'h8000 + DL[j]));
            cmp_bit(det1, det_exp(2'(m), 1'b0, 32'h8000, 32'h200, 32'h8000 + DL[j]));
         end
      end
      wr(ATD_OFS_CONFIG, 8'h38);
      wr(ATD_OFS_SETUP1, 8'h1F);
      foreach (HY[j]) begin
         if (j == 3)
            wr(ATD_OFS_SETUP1, 8'h0F);
         conv(HY[j]);
         cmp_bit(det1, HX[j]);
      end
      // Approach waits three conversions, recede only one
      snap();
      wr(ATD_OFS_TMO1, 8'h31);
      repeat (2) conv(16'h9000);
      rd(ATD_OFS_AVG1);
      cmp_word(rdv, 32'h8000);
      conv(16'h9000);
      rd(ATD_OFS_AVG1);
      cmp_word(rdv, 32'h9000);
      conv(16'h0000);
      rd(ATD_OFS_AVG1);
      cmp_word(rdv, 32'h0);
      s = $urandom_range(2, 0);
      st = 1 << $urandom_range(2, 0);
      wr(ATD_OFS_SETUP1, 8'(s | (st == 2 ? 8'h40 : st == 4 ? 8'h80 : 0)));
      snap();
      wr(ATD_OFS_DAC1, 8'hC0);
      avg = 32'h8000;
      dac = 0;
      for (int k = 0; k < 80; k++) begin
         dv = (k < 30) ? 16'hFFF0 : 16'h0000;
         if (avg > 32'hA800)
            dac = (dac + st > 63) ? 63 : dac + st;
         else if (avg < 32'h5800)
            dac = (dac < st) ? 0 : dac - st;
         // Signed shift floors like the hardware on a falling average
         avg = avg + ((int'(dv) - avg) >>> (s + 1));
         conv(dv);
         if (k < 30 || k == 79) begin
            rd(ATD_OFS_AVG1);
            cmp_word(rdv, avg);
            cmp_word({26'h0, dac1}, dac);
         end
      end
      wr(ATD_OFS_PDTIMER, 8'h41);
      repeat (24) conv(16'h0000);
      cmp_bit(pd, 1'b1);
      conv(16'hFFF0);
      cmp_bit(det1, 1'b0);
      wr(ATD_OFS_WAKE, 8'h00);
      // Output flop adds one cycle after the write lands
      repeat (2) @(negedge mclk_in);
      cmp_bit(pd, 1'b0);
      results();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      results();
   end
endmodule // atd_detector_tb
